// File: rtl/icc_pkg.sv
// Constants, field positions and codes of the input capture channel.
// Assumes a 16-bit register port with a 2-bit word index.
package icc_pkg;
  // ----------------------------------------------------------------
  // Register indices
  // ----------------------------------------------------------------
  localparam logic [1:0] IDX_CTL1 = 2'h0;
  localparam logic [1:0] IDX_CTL2 = 2'h1;
  localparam logic [1:0] IDX_BUF  = 2'h2;
  localparam logic [1:0] IDX_CNT  = 2'h3;
  // ----------------------------------------------------------------
  // Control one fields
  // ----------------------------------------------------------------
  localparam int B_IDLE = 13;
  localparam int B_CKHI = 12;
  localparam int B_CKLO = 10;
  localparam int B_IRHI = 6;
  localparam int B_IRLO = 5;
  localparam int B_OVF  = 4;
  localparam int B_BNE  = 3;
  localparam int B_MDHI = 2;
  // ----------------------------------------------------------------
  // Control two fields
  // ----------------------------------------------------------------
  localparam int B_CASC = 8;
  localparam int B_TSEL = 7;
  localparam int B_TSTA = 6;
  localparam int B_SSHI = 4;
  // ----------------------------------------------------------------
  // Reset values and codes
  // ----------------------------------------------------------------
  localparam logic [2:0] CLK_RST  = 3'h0;
  localparam logic [4:0] SYNC_RST = 5'h0D;
  localparam logic [4:0] SYNC_NO0 = 5'h00;
  localparam logic [4:0] SYNC_NO1 = 5'h1F;
  localparam logic [2:0] CK_PERI  = 3'h7;
  localparam logic [2:0] CK_T1    = 3'h4;
  localparam logic [2:0] CK_T5    = 3'h3;
  localparam logic [2:0] CK_T4    = 3'h2;
  localparam logic [2:0] CK_T2    = 3'h1;
  localparam logic [2:0] CK_T3    = 3'h0;
  localparam logic [3:0] PRE4_END  = 4'h3;
  localparam logic [3:0] PRE16_END = 4'hF;
  localparam logic [15:0] CNT_MAX  = 16'hFFFF;
  typedef enum logic [2:0] {
    M_OFF   = 3'b000,
    M_BOTH  = 3'b001,
    M_FALL  = 3'b010,
    M_RISE  = 3'b011,
    M_RISE4 = 3'b100,
    M_RISE16= 3'b101,
    M_UNUSED= 3'b110,
    M_WAKE  = 3'b111
  } icc_mode_t;
endpackage

// File: rtl/icc_fifo_if.sv
// Link between the channel core and its capture buffer.
// Assumes both ends sit on the same clock.
`timescale 1ns/1ps
`default_nettype none
interface icc_fifo_if #(parameter int W = 16);
  logic         push;
  logic [W-1:0] pushData;
  logic         pop;
  logic         flush;
  logic [W-1:0] head;
  logic         full;
  logic         empty;
  modport core (output push, pushData, pop, flush, input head, full, empty);
  modport buff (input push, pushData, pop, flush, output head, full, empty);
endinterface
`default_nettype wire

// File: rtl/icc_fifo.sv
// Capture buffer: a small first-in first-out store of counter values.
// A pop when empty is ignored; a push when full is dropped unless a pop comes in the same cycle.
`timescale 1ns/1ps
`default_nettype none
module icc_fifo #(
  parameter int W     = 16,
  parameter int DEPTH = 4
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // Core side
  icc_fifo_if.buff f
);
  localparam int AW = $clog2(DEPTH);
  initial begin
    if (DEPTH < 2 || (1 << AW) != DEPTH) $error("DEPTH must be a power of two");
  end
  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0]           wrPtr;
    logic [AW-1:0]           rdPtr;
    logic [AW:0]             count;
  } icc_fifo_st_t;
  icc_fifo_st_t st_reg;
  icc_fifo_st_t st_next;
  logic doPush;
  logic doPop;
  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    st_next = st_reg;
    doPop   = f.pop && (st_reg.count != '0);
    // A pop in the same cycle frees a slot, so a push on full still lands
    doPush  = f.push && ((st_reg.count != (AW+1)'(DEPTH)) || doPop);
    if (doPush) begin
      st_next.mem[st_reg.wrPtr] = f.pushData;
      st_next.wrPtr             = st_reg.wrPtr + 1'b1;
    end
    if (doPop) begin
      st_next.rdPtr = st_reg.rdPtr + 1'b1;
    end
    st_next.count = st_reg.count + (AW+1)'(doPush) - (AW+1)'(doPop);
    // Flush drops everything, data words kept only as garbage
    if (f.flush) begin
      st_next.wrPtr = '0;
      st_next.rdPtr = '0;
      st_next.count = '0;
    end
  end
  // State register
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end
  assign f.head  = st_reg.mem[st_reg.rdPtr];
  assign f.full  = (st_reg.count == (AW+1)'(DEPTH));
  assign f.empty = (st_reg.count == '0);
endmodule
`default_nettype wire

// File: rtl/icc_channel.sv
// What this block does
// - Two adjacent channels cascade into 32 bits
// - Captured values kept in four-entry FIFO
// - Own 16-bit counter, six clock sources
// - Counter syncs or triggers from 30 sources
// - Reset selects third timer as sync source
// - Stop-in-idle bit halts channel in Idle
// - Three-bit clock select decode table
// - Timer one clock used synchronously only
// - Interrupt after one to four captures
// - Rate ignored in modes 001 and 111
// - Overflow flag hardware set, read-only
// - Not-empty flag while unread data remains
// - Mode 111: rising-edge wake pin only
// - Modes 110 and 000 disable the channel
// - Mode 101 captures every sixteenth rise
// - Mode 100 captures every fourth rise
// - 011 rising, 010 falling edge capture
// - Mode 001 captures both edges
// - Cascade needs both channels' cascade bits
// - Trigger bit: start versus synchronize counter
// - Trigger status held, settable, clears counter
// - Source default third timer; 0, 31 none
//
// One input capture channel with a 16-bit register port.
// Assumes timer ticks and sync sources are one-cycle enables on clk_sys.
//
// Decided for this implementation: the plain strobed port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module icc_channel
  import icc_pkg::*;
#(
  parameter int  W      = 16,
  parameter int  DEPTH  = 4,
  parameter bit  IS_ODD = 1'b0
) (
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        sys_rst,
  // Register port
  input  wire logic [1:0]  regAddr,
  input  wire logic [15:0] regWrData,
  input  wire logic        regWr,
  input  wire logic        regRd,
  output logic      [15:0] regRdData,
  // Capture pin and power state
  input  wire logic        captureIn,
  input  wire logic        cpuIdle,
  input  wire logic        cpuSleep,
  // Timer ticks one..five, sync sources by code
  input  wire logic [4:0]  timerTick,
  input  wire logic [31:0] syncSource,
  // Cascade partner
  input  wire logic        partnerCascade,
  input  wire logic        carryIn,
  output logic             carryOut,
  output logic             cascadeOut,
  // Events
  output logic             captureIrq,
  output logic             wakeIrq
);
  import icc_pkg::*;
  initial begin
    if (W != 16) $error("W must be 16");
    if (DEPTH != 4) $error("DEPTH must be 4");
  end
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic        idleHalt;
    logic [2:0]  clkSel;
    logic [1:0]  perIrq;
    logic [2:0]  mode;
    logic        cascade;
    logic        trigSel;
    logic        trigger_status;
    logic [4:0]  sync_source_sel;
    logic        ovf;
    logic        pinMeta;
    logic        pinSync;
    logic        pinPrev;
    logic [15:0] counter;
    logic [3:0]  preCnt;
    logic [1:0]  irqCnt;
    logic [15:0] rdData;
    logic        irq;
    logic        wake;
    logic        carry;
  } icc_state_t;
  icc_state_t s_reg;
  icc_state_t s_next;
  icc_fifo_if #(.W(W)) fif ();
  icc_fifo #(
    .W    (W),
    .DEPTH(DEPTH)
  ) u_fifo (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .f      (fif.buff)
  );
  // ----------------------------------------------------------------
  // Decoders
  // ----------------------------------------------------------------
  // Clock source pick; timer one tick is an on-clock enable only
  function automatic logic clkPick(logic [2:0] sel, logic [4:0] t);
    logic r;
    r = 1'b0;
    case (sel)
      CK_PERI: r = 1'b1;
      CK_T1:   r = t[0];
      CK_T5:   r = t[4];
      CK_T4:   r = t[3];
      CK_T2:   r = t[1];
      CK_T3:   r = t[2];
      default: r = 1'b0;  // Reserved codes give no tick
    endcase
    return r;
  endfunction
  // Sync or trigger source pick; both end codes mean no source
  function automatic logic srcPick(logic [4:0] sel, logic [31:0] src);
    logic r;
    r = src[sel];
    if (sel == SYNC_NO0 || sel == SYNC_NO1) begin
      r = 1'b0;
    end
    return r;
  endfunction
  // Capture modes that feed the buffer
  function automatic logic isCapMode(logic [2:0] m);
    return (m != M_OFF) && (m != M_UNUSED) && (m != M_WAKE);
  endfunction
  // ----------------------------------------------------------------
  // Working signals
  // ----------------------------------------------------------------
  logic wrCtl1;
  logic wrCtl2;
  logic wrCnt;
  logic rdBuf;
  logic cascaded;
  logic halted;
  logic capOn;
  logic tick;
  logic srcHit;
  logic rise;
  logic fall;
  logic capEvt;
  logic rateWrap;
  always_comb begin
    wrCtl1   = regWr && (regAddr == IDX_CTL1);
    wrCtl2   = regWr && (regAddr == IDX_CTL2);
    wrCnt    = regWr && (regAddr == IDX_CNT);
    rdBuf    = regRd && (regAddr == IDX_BUF);
    cascaded = s_reg.cascade && partnerCascade;
    halted   = s_reg.idleHalt && cpuIdle;
    capOn    = isCapMode(s_reg.mode) && !halted;
    // Odd half of a cascaded pair counts the even half's carries
    tick     = (cascaded && IS_ODD) ? carryIn : clkPick(s_reg.clkSel, timerTick);
    srcHit   = srcPick(s_reg.sync_source_sel, syncSource);
    rise     = s_reg.pinSync && !s_reg.pinPrev;
    fall     = !s_reg.pinSync && s_reg.pinPrev;
  end
  // ----------------------------------------------------------------
  // Capture event qualification
  // ----------------------------------------------------------------
  always_comb begin
    capEvt = 1'b0;
    case (s_reg.mode)
      M_BOTH:   capEvt = rise || fall;
      M_FALL:   capEvt = fall;
      M_RISE:   capEvt = rise;
      M_RISE4:  capEvt = rise && (s_reg.preCnt == PRE4_END);
      M_RISE16: capEvt = rise && (s_reg.preCnt == PRE16_END);
      default:  capEvt = 1'b0;
    endcase
    capEvt   = capEvt && capOn;
    rateWrap = (s_reg.irqCnt == s_reg.perIrq);
  end
  // Buffer requests
  always_comb begin
    fif.push     = capEvt;
    fif.pushData = s_reg.counter;
    fif.pop      = rdBuf;
    fif.flush    = (s_reg.mode == M_OFF);
  end
  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    s_next         = s_reg;
    s_next.irq     = 1'b0;
    s_next.wake    = 1'b0;
    s_next.carry   = 1'b0;
    // Pin synchroniser; the first stage feeds only the second
    s_next.pinMeta = captureIn;
    s_next.pinSync = s_reg.pinMeta;
    s_next.pinPrev = s_reg.pinSync;
    // Software writes; overflow and not-empty bits are not writable here, trigger status is
    if (wrCtl1) begin
      s_next.idleHalt = regWrData[B_IDLE];
      s_next.clkSel   = regWrData[B_CKHI:B_CKLO];
      s_next.perIrq   = regWrData[B_IRHI:B_IRLO];
      s_next.mode     = regWrData[B_MDHI:0];
    end
    if (wrCtl2) begin
      s_next.cascade  = regWrData[B_CASC];
      s_next.trigSel  = regWrData[B_TSEL];
      s_next.trigger_status = regWrData[B_TSTA];
      s_next.sync_source_sel  = regWrData[B_SSHI:0];
    end
    // Source sets trigger status after software, so a set wins
    if (s_reg.trigSel && srcHit) begin
      s_next.trigger_status = 1'b1;
    end
    // Counter: held clear, restarted by sync, or advanced on tick
    if (s_reg.trigSel && !s_reg.trigger_status) begin
      s_next.counter = '0;
    end else if (!s_reg.trigSel && srcHit) begin
      s_next.counter = '0;
    end else if (tick && !halted && isCapMode(s_reg.mode)) begin
      s_next.counter = s_reg.counter + 16'h0001;
      s_next.carry   = (s_reg.counter == CNT_MAX);
    end
    if (wrCnt) begin
      s_next.counter = regWrData;
    end
    // Prescaler for the divided rising-edge modes
    if (capOn && rise) begin
      s_next.preCnt = s_reg.preCnt + 4'h1;
      if (capEvt) begin
        s_next.preCnt = '0;
      end
    end
    // Interrupt rate count; edge detect mode ignores the rate
    if (capEvt) begin
      if (s_reg.mode == M_BOTH || rateWrap) begin
        s_next.irq    = 1'b1;
        s_next.irqCnt = '0;
      end else begin
        s_next.irqCnt = s_reg.irqCnt + 2'h1;
      end
      if (fif.full && !rdBuf) begin
        s_next.ovf = 1'b1;
      end
    end
    // Wake pin: rising edge in Sleep or Idle, no capture at all
    if (s_reg.mode == M_WAKE && rise && (cpuSleep || cpuIdle)) begin
      s_next.wake = 1'b1;
    end
    // Turning the channel off clears its progress
    if (s_reg.mode == M_OFF) begin
      s_next.ovf    = 1'b0;
      s_next.preCnt = '0;
      s_next.irqCnt = '0;
    end
    // Read data, shown in the cycle after the strobe only
    s_next.rdData = '0;
    if (regRd) begin
      case (regAddr)
        IDX_CTL1: begin
          s_next.rdData[B_IDLE]        = s_reg.idleHalt;
          s_next.rdData[B_CKHI:B_CKLO] = s_reg.clkSel;
          s_next.rdData[B_IRHI:B_IRLO] = s_reg.perIrq;
          s_next.rdData[B_OVF]         = s_reg.ovf;
          s_next.rdData[B_BNE]         = !fif.empty;
          s_next.rdData[B_MDHI:0]      = s_reg.mode;
        end
        IDX_CTL2: begin
          s_next.rdData[B_CASC]   = s_reg.cascade;
          s_next.rdData[B_TSEL]   = s_reg.trigSel;
          s_next.rdData[B_TSTA]   = s_reg.trigger_status;
          s_next.rdData[B_SSHI:0] = s_reg.sync_source_sel;
        end
        IDX_BUF: s_next.rdData = fif.empty ? '0 : fif.head;
        IDX_CNT: s_next.rdData = s_reg.counter;
        default: s_next.rdData = '0;
      endcase
    end
  end
  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      s_reg         <= '0;
      s_reg.clkSel  <= CLK_RST;
      s_reg.sync_source_sel <= SYNC_RST;
    end else begin
      s_reg <= s_next;
    end
  end
  // Outputs, all straight from flops
  assign regRdData  = s_reg.rdData;
  assign captureIrq = s_reg.irq;
  assign wakeIrq    = s_reg.wake;
  assign carryOut   = s_reg.carry;
  assign cascadeOut = s_reg.cascade;
endmodule
`default_nettype wire

// File: sim/icc_checker_sva.sv
// Port-level checker for one capture channel.
// Assumes it is bound onto icc_channel and shares its single clock.
`timescale 1ns/1ps
`default_nettype none
module icc_checker
  import icc_pkg::*;
(
  // Clock, reset and register port
  input wire logic        clk_sys,
  input wire logic        sys_rst,
  input wire logic [1:0]  regAddr,
  input wire logic [15:0] regWrData,
  input wire logic        regWr,
  input wire logic        regRd,
  input wire logic [15:0] regRdData,
  // Pin, power state and events
  input wire logic        captureIn,
  input wire logic        cpuIdle,
  input wire logic        cpuSleep,
  input wire logic        carryOut,
  input wire logic        cascadeOut,
  input wire logic        captureIrq,
  input wire logic        wakeIrq
);
  logic [15:0] ctl1;
  logic        casc;
  logic [3:0]  age1;
  logic [3:0]  age2;
  logic [3:0]  idleAge;
  logic [7:0]  pinHist;
  logic        lowPwr;
  logic [2:0]  mode;
  assign lowPwr = cpuIdle | cpuSleep;
  assign mode = ctl1[2:0];
  // Shadow of control writes; ages saturate so long idle spans stay cheap
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      ctl1 <= 16'h0000;
      casc <= 1'b0;
      age1 <= 4'hF;
      age2 <= 4'hF;
      idleAge <= 4'h0;
      pinHist <= 8'h00;
    end else begin
      if (regWr && regAddr == IDX_CTL1) ctl1 <= regWrData;
      if (regWr && regAddr == IDX_CTL2) casc <= regWrData[B_CASC];
      age1 <= (regWr && regAddr == IDX_CTL1) ? 4'h0 : ((age1 == 4'hF) ? age1 : age1 + 4'h1);
      age2 <= (regWr && regAddr == IDX_CTL2) ? 4'h0 : ((age2 == 4'hF) ? age2 : age2 + 4'h1);
      idleAge <= !cpuIdle ? 4'h0 : ((idleAge == 4'hF) ? idleAge : idleAge + 4'h1);
      pinHist <= {pinHist[6:0], captureIn};
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  chk_rd_quiet: assert property (
    !$past(regRd) |-> regRdData == 16'h0000) else $error("read data not idle");
  chk_off_quiet: assert property (
    (mode == M_OFF || mode == M_UNUSED) && age1 >= 4'h5 |-> !captureIrq && !wakeIrq)
    else $error("event while channel off");
  chk_wake_only: assert property (
    age1 >= 4'h5 |-> ((mode == M_WAKE) ? !captureIrq : !wakeIrq))
    else $error("wrong event kind for mode");
  chk_wake_lowpwr: assert property (
    wakeIrq |-> $past(lowPwr)) else $error("wake event while awake");
  chk_irq_cause: assert property (
    captureIrq || wakeIrq |-> !(&pinHist[6:1]) && (|pinHist[6:1]))
    else $error("event without pin edge");
  chk_idle_halt: assert property (
    ctl1[B_IDLE] && idleAge >= 4'h5 && age1 >= 4'h5 |-> !captureIrq)
    else $error("capture while halted in idle");
  chk_carry_pulse: assert property (
    carryOut |=> !carryOut) else $error("carry longer than one cycle");
  chk_casc_follow: assert property (
    age2 >= 4'h3 |-> cascadeOut == casc) else $error("cascade out mismatch");
  chk_reset_quiet: assert property (
    $fell(sys_rst) |-> !captureIrq && !wakeIrq && !carryOut && !cascadeOut)
    else $error("outputs busy after reset");
endmodule
bind icc_channel icc_checker icc_checker_i (.clk_sys(clk_sys), .sys_rst(sys_rst),
  .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
  .regRdData(regRdData), .captureIn(captureIn), .cpuIdle(cpuIdle), .cpuSleep(cpuSleep),
  .carryOut(carryOut), .cascadeOut(cascadeOut), .captureIrq(captureIrq), .wakeIrq(wakeIrq));
`default_nettype wire

// File: sim/icc_pin_model.sv
// Model of the measured signal driving the capture pin.
// Assumes the channel synchronises the pin; phases are six cycles long.
`timescale 1ns/1ps
`default_nettype none
module icc_pin_model (
  // Clock
  input wire logic clk_sys,
  // Measured pin
  output logic     pinLevel
);
  initial pinLevel = 1'b0;
  // Long phases so each edge clears the synchroniser before the next
  task automatic pulse(input int n);
    repeat (n) begin
      @(posedge clk_sys);
      pinLevel <= 1'b1;
      repeat (6) @(posedge clk_sys);
      pinLevel <= 1'b0;
      repeat (6) @(posedge clk_sys);
    end
  endtask
endmodule
`default_nettype wire

// File: sim/tb_top.sv
// Self-checking bench for one capture channel over its register port.
// Assumes timer ticks stay low unless pulsed, freezing the counter.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import icc_pkg::*;
  logic clk_sys = 1'b0;
  logic sys_rst, regWr, regRd, cpuIdle, cpuSleep, partnerCascade, carryIn;
  logic [1:0] regAddr;
  logic [15:0] regWrData, rdv;
  logic [4:0] timerTick;
  logic [31:0] syncSource;
  logic [15:0] regRdData;
  logic captureIn, carryOut, cascadeOut, captureIrq, wakeIrq;
  int error_cnt = 0, n_tests = 0, irqCnt = 0, wakeCnt = 0, carryCnt = 0, e, expTot;
  logic [2:0] ckSel [5] = '{3'b100, 3'b001, 3'b000, 3'b010, 3'b011};
  logic [2:0] modes [5] = '{3'b011, 3'b010, 3'b001, 3'b100, 3'b101};
  logic [2:0] md;
  always #5 clk_sys = ~clk_sys;
  // Odd half of a pair, so the cascade test can feed it partner carries
  icc_channel #(.IS_ODD(1'b1)) icc_channel_i (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
    .regRdData(regRdData), .captureIn(captureIn), .cpuIdle(cpuIdle), .cpuSleep(cpuSleep),
    .timerTick(timerTick), .syncSource(syncSource), .partnerCascade(partnerCascade),
    .carryIn(carryIn), .carryOut(carryOut), .cascadeOut(cascadeOut), .captureIrq(captureIrq),
    .wakeIrq(wakeIrq));
  icc_pin_model icc_pin_model_i (.clk_sys(clk_sys), .pinLevel(captureIn));
  // Event counters sample mid-cycle, away from the edge that launches a pulse
  always @(negedge clk_sys) begin
    if (captureIrq === 1'b1) irqCnt++;
    if (wakeIrq === 1'b1) wakeCnt++;
    if (carryOut === 1'b1) carryCnt++;
  end
  task automatic wr(input logic [1:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    regWr <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge clk_sys);
    regWr <= 1'b0;
  endtask
  // Data stand only in the cycle after the strobe edge
  task automatic rd(input logic [1:0] a);
    @(posedge clk_sys);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge clk_sys);
    regRd <= 1'b0;
    #1 rdv = regRdData;
  endtask
  task automatic tick(input logic [4:0] t, input logic [31:0] s);
    @(posedge clk_sys);
    timerTick <= t;
    syncSource <= s;
    @(posedge clk_sys);
    timerTick <= 5'h00;
    syncSource <= 32'h0000_0000;
  endtask
  task automatic cmp(input string n, input logic [15:0] x, input logic [15:0] g);
    n_tests++;
    if (g !== x) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", n, x, g);
    end
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // Watchdog well above the few thousand cycles the tests need
  initial begin
    repeat (40000) @(posedge clk_sys);
    error_cnt++;
    tally_and_finish();
  end
  initial begin
    sys_rst <= 1'b1;
    regWr <= 1'b0;
    regRd <= 1'b0;
    cpuIdle <= 1'b0;
    cpuSleep <= 1'b0;
    partnerCascade <= 1'b0;
    carryIn <= 1'b0;
    regAddr <= 2'h0;
    regWrData <= 16'h0000;
    timerTick <= 5'h00;
    syncSource <= 32'h0000_0000;
    repeat (4) @(posedge clk_sys);
    sys_rst <= 1'b0;
    rd(IDX_CTL1); cmp("ctl1 reset", 16'h0000, rdv);
    rd(IDX_CTL2); cmp("ctl2 reset", 16'h000D, rdv);
    wr(IDX_BUF, 16'hABCD); rd(IDX_BUF); cmp("empty buffer", 16'h0000, rdv);
    $display("reset test done");
    wr(IDX_CTL2, 16'h0000);
    for (int i = 0; i < 5; i++) begin
      wr(IDX_CTL1, {3'b000, ckSel[i], 7'h00, 3'b011});
      wr(IDX_CNT, 16'h0000);
      repeat (3) tick(5'h01 << i, 32'h0000_0000);
      tick(~(5'h01 << i), 32'h0000_0000);
      rd(IDX_CNT); cmp("selected clock count", 16'h0003, rdv);
    end
    wr(IDX_CTL1, 16'h1C03); wr(IDX_CNT, 16'h0000);
    rd(IDX_CNT); cmp("peripheral clock runs", 16'h0001, {15'h0, rdv != 16'h0000});
    $display("clock select test done");
    foreach (modes[m]) begin
      md = modes[m];
      wr(IDX_CTL1, 16'h0000);
      wr(IDX_CTL1, {6'b000001, 3'b000, (md == 3'b001) ? 2'b11 : 2'b00, 2'b00, md});
      irqCnt = 0;
      expTot = 0;
      for (int k = 1; k <= 16; k++) begin
        wr(IDX_CNT, 16'(k));
        icc_pin_model_i.pulse(1);
        e = (md == 3'b001) ? 2 : (md == 3'b100) ? int'(k % 4 == 0) :
            (md == 3'b101) ? int'(k == 16) : 1;
        expTot += e;
        rd(IDX_CTL1); cmp("not empty flag", 16'(e > 0), {15'h0, rdv[B_BNE]});
        repeat (e) begin
          rd(IDX_BUF); cmp("captured value", 16'(k), rdv);
        end
      end
      cmp("capture events", 16'(expTot), 16'(irqCnt));
    end
    $display("edge mode test done");
    for (int r = 0; r < 4; r++) begin
      wr(IDX_CTL1, 16'h0000);
      wr(IDX_CTL1, {6'b000001, 3'b000, 2'(r), 2'b00, 3'b011});
      irqCnt = 0;
      for (int k = 1; k <= 4; k++) begin
        wr(IDX_CNT, 16'(k));
        icc_pin_model_i.pulse(1);
      end
      cmp("events per rate", 16'(4 / (r + 1)), 16'(irqCnt));
    end
    wr(IDX_CNT, 16'h0005); icc_pin_model_i.pulse(1);
    rd(IDX_CTL1); cmp("overflow set", 16'h047B, rdv);
    wr(IDX_CTL1, 16'h0463); rd(IDX_CTL1); cmp("flags read only", 16'h047B, rdv);
    for (int k = 1; k <= 4; k++) begin
      rd(IDX_BUF); cmp("buffer order", 16'(k), rdv);
    end
    rd(IDX_CTL1); cmp("drained", 16'h0473, rdv);
    wr(IDX_CTL1, 16'h0018); rd(IDX_CTL1); cmp("off clears", 16'h0000, rdv);
    wr(IDX_CTL1, 16'h0006); icc_pin_model_i.pulse(1);
    rd(IDX_CTL1); cmp("unused mode idle", 16'h0006, rdv);
    $display("buffer test done");
    wr(IDX_CTL1, 16'h0067); cpuSleep <= 1'b1; wakeCnt = 0; irqCnt = 0;
    icc_pin_model_i.pulse(1); cpuSleep <= 1'b0;
    icc_pin_model_i.pulse(1);
    cmp("wake events", 16'h0001, 16'(wakeCnt));
    rd(IDX_CTL1); cmp("wake no capture", 16'h0000, {15'h0, rdv[B_BNE]});
    wr(IDX_CTL1, 16'h2403); cpuIdle <= 1'b1; wr(IDX_CNT, 16'h0007);
    icc_pin_model_i.pulse(1);
    rd(IDX_CTL1); cmp("idle halted", 16'h0000, {15'h0, rdv[B_BNE]});
    wr(IDX_CTL1, 16'h0403); icc_pin_model_i.pulse(1);
    rd(IDX_BUF); cmp("idle running", 16'h0007, rdv);
    cpuIdle <= 1'b0;
    $display("power test done");
    wr(IDX_CTL2, 16'h008C); tick(5'h02, 32'h0000_0000);
    rd(IDX_CNT); cmp("held clear", 16'h0000, rdv);
    tick(5'h00, 32'h0000_1000);
    rd(IDX_CTL2); cmp("status set", 16'h00CC, rdv);
    repeat (2) tick(5'h02, 32'h0000_0000);
    rd(IDX_CNT); cmp("triggered count", 16'h0002, rdv);
    wr(IDX_CTL2, 16'h008C); rd(IDX_CNT); cmp("status cleared", 16'h0000, rdv);
    wr(IDX_CTL2, 16'h000C); wr(IDX_CNT, 16'h0005); tick(5'h00, 32'h0000_1000);
    rd(IDX_CNT); cmp("sync zeroes", 16'h0000, rdv);
    wr(IDX_CTL2, 16'h001F); wr(IDX_CNT, 16'h0005); tick(5'h00, 32'h8000_0000);
    rd(IDX_CNT); cmp("no source", 16'h0005, rdv);
    $display("trigger test done");
    wr(IDX_CTL2, 16'h011F); wr(IDX_CNT, 16'h0005); tick(5'h02, 32'h0000_0000);
    rd(IDX_CNT); cmp("single cascade bit", 16'h0006, rdv);
    @(posedge clk_sys);
    partnerCascade <= 1'b1;
    repeat (2) @(posedge clk_sys);
    #1 cmp("cascade out", 16'h0001, {15'h0, cascadeOut});
    wr(IDX_CNT, 16'hFFFF); carryCnt = 0; tick(5'h02, 32'h0000_0000);
    rd(IDX_CNT); cmp("odd ignores tick", 16'hFFFF, rdv);
    @(posedge clk_sys);
    carryIn <= 1'b1;
    @(posedge clk_sys);
    carryIn <= 1'b0;
    repeat (2) @(posedge clk_sys);
    cmp("carry pulses", 16'h0001, 16'(carryCnt));
    rd(IDX_CNT); cmp("rolled over", 16'h0000, rdv);
    $display("cascade test done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
